//--- hw/astc_pkg.sv
package astc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CONFIG      = 8'h00;
  localparam logic [7:0] ADDR_SHUTTER     = 8'h04;
  localparam logic [7:0] ADDR_EXPOSURE    = 8'h08;
  localparam logic [7:0] ADDR_COMMAND     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS      = 8'h10;
  localparam logic [7:0] ADDR_MEASURED    = 8'h14;
  localparam logic [7:0] ADDR_MENU_PERIOD = 8'h18;

  // Configuration word field positions
  localparam int CFG_PWC_BIT      = 0;
  localparam int CFG_HRESET_BIT   = 1;
  localparam int CFG_AEC_BIT      = 2;
  localparam int CFG_AGC_BIT      = 3;
  localparam int CFG_LONG_BIT     = 4;
  localparam int CFG_STROBE_TIMING_OUT_LO_BIT  = 5;
  localparam int CFG_STROBE_TIMING_OUT_HI_BIT  = 6;
  localparam int CFG_IRIS_BIT     = 7;
  localparam int CFG_ASYNC_BIT    = 8;
  localparam int CFG_MENU_BIT     = 9;
  localparam int CONFIG_W         = 10;
  localparam int CMD_SW_TRIG_BIT  = 0;

  // Widths and reset values
  localparam int                  SHUTTER_W        = 4;
  localparam int                  LINE_W           = 16;
  localparam logic [9:0]          CONFIG_RESET     = 10'h000;
  localparam logic [3:0]          SHUTTER_RESET    = 4'h0;
  localparam logic [3:0]          SHUTTER_NONE     = 4'h0;
  localparam logic [3:0]          SHUTTER_PULSE    = 4'h9;
  localparam logic [15:0]         EXPOSURE_RESET   = 16'h0010;
  localparam logic [15:0]         MENU_PERIOD_RESET = 16'h0400;

  // Strobe pin source select {high, low}
  localparam logic [1:0] STROBE_TIMING_OUT_SEL_OFF    = 2'h0;
  localparam logic [1:0] STROBE_TIMING_OUT_SEL_STROBE = 2'h1;
  localparam logic [1:0] STROBE_TIMING_OUT_SEL_BUSY   = 2'h2;

  // Timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int LED_TIME_MS = 100;
  localparam int LED_CYCLES  = LED_TIME_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    MODE_NONE  = 2'h0,
    MODE_CONT  = 2'h1,
    MODE_ASYNC = 2'h2
  } astc_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ARMED   = 3'h1,
    ST_MEASURE = 3'h3,
    ST_EXPOSE  = 3'h2,
    ST_READOUT = 3'h6
  } astc_state_t;

endpackage

//--- hw/astc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module astc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Level from another domain and its synchronised copy
  input  wire logic d,
  output var  logic q
);

  typedef struct packed {
    logic first;
    logic second;
  } astc_sync_st_t;

  astc_sync_st_t r_reg;
  astc_sync_st_t r_next;

  // Two stages; only the second stage is seen outside
  always_comb begin
    r_next.first  = d;
    r_next.second = r_reg.first;
  end

  // Idle level of the trigger line is high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '{first: 1'b1, second: 1'b1};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.second;

endmodule
`default_nettype wire

//--- hw/astc_oneshot.sv
`timescale 1ns/10ps
`default_nettype none
module astc_oneshot #(
  parameter int CYCLES = 4_000_000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Start or restart pulse and lit output
  input  wire logic fire,
  output var  logic active
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
  } astc_os_st_t;

  astc_os_st_t r_reg;
  astc_os_st_t r_next;

  // A new fire reloads the full period, stretching the lit time
  always_comb begin
    r_next = r_reg;
    if (fire) begin
      r_next.count = CW'(CYCLES);
    end else if (r_reg.count != '0) begin
      r_next.count = r_reg.count - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign active = (r_reg.count != '0);

endmodule
`default_nettype wire

//--- hw/astc_top.sv
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module astc_top #(
  parameter int LINE_CYCLES   = 1000,
  parameter int READOUT_LINES = 1040,
  parameter int FRAME_LINES   = 1300,
  parameter int LED_CYCLES    = astc_pkg::LED_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  // Trigger pin, active low
  input  wire logic        trigger_n_pin,
  // Strobe pin and indicator
  output var  logic        strobe_pin,
  output var  logic        indicator_led,
  // Exposure status
  output var  logic        busy,
  output var  logic        exposing,
  output var  logic        horizontal_sync_pulse,
  // Function permissions
  output var  logic        agc_allowed,
  output var  logic        aec_allowed,
  output var  logic        long_exposure_allowed,
  output var  logic        auto_iris_allowed,
  output var  logic        aec_active
);

  localparam int LW = astc_pkg::LINE_W;

  typedef struct packed {
    logic [astc_pkg::CONFIG_W-1:0]  configuration_word;
    logic [astc_pkg::SHUTTER_W-1:0] shutter;
    logic [LW-1:0]                  exposure;
    logic [LW-1:0]                  menu_period;
    logic [LW-1:0]                  measured;
    logic [31:0]                    rdata;
    astc_pkg::astc_state_t          state;
    logic [LW-1:0]                  line_pix;
    logic                           hs;
    logic [LW-1:0]                  lines;
    logic [LW-1:0]                  target;
    logic                           internal;
    logic                           trig_d;
    logic                           sw_trig;
    logic [LW-1:0]                  menu_lines;
    logic [LW-1:0]                  cont_line;
    logic                           strobe;
    logic                           led;
    logic                           busy;
    logic                           exposing;
    logic [3:0]                     allowed;
    logic                           aec_active;
  } astc_st_t;

  astc_st_t r_reg;
  astc_st_t r_next;

  logic trig_q;
  logic led_on;
  logic fall;
  logic ext_fire;
  logic menu_fire;
  logic led_fire;

  // Trigger pin synchroniser
  astc_sync u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (trigger_n_pin),
    .q      (trig_q)
  );

  // Retriggerable indicator timer
  astc_oneshot #(
    .CYCLES (LED_CYCLES)
  ) u_led (
    .clk    (clk),
    .arst_n (arst_n),
    .fire   (led_fire),
    .active (led_on)
  );

  // Mode decode, trigger events and the exposure sequence
  always_comb begin
    astc_pkg::astc_mode_t mode;
    logic                 pwm;
    logic                 hreset;
    logic                 menu;
    logic                 accept;
    logic                 sample;
    logic [1:0]           sel;
    logic                 strobe_t;
    logic [LW-1:0]        done_lines;
    mode     = astc_pkg::MODE_NONE;
    pwm      = 1'b0;
    hreset   = 1'b0;
    menu     = 1'b0;
    accept   = 1'b0;
    sample   = 1'b0;
    sel      = 2'h0;
    strobe_t = 1'b0;
    done_lines = '0;
    r_next   = r_reg;
    r_next.sw_trig = 1'b0;
    r_next.rdata   = 32'h0;

    hreset = r_reg.configuration_word[astc_pkg::CFG_HRESET_BIT];
    menu   = r_reg.configuration_word[astc_pkg::CFG_MENU_BIT];

    // Shutter mode from stored value and flags
    if (r_reg.shutter == astc_pkg::SHUTTER_NONE) begin
      if (r_reg.configuration_word[astc_pkg::CFG_AEC_BIT]) begin
        mode = astc_pkg::MODE_CONT;
      end else begin
        mode = astc_pkg::MODE_NONE;
      end
    end else if (r_reg.configuration_word[astc_pkg::CFG_ASYNC_BIT]) begin
      mode = astc_pkg::MODE_ASYNC;
    end else begin
      mode = astc_pkg::MODE_CONT;
    end
    pwm = (mode == astc_pkg::MODE_ASYNC) &&
          r_reg.configuration_word[astc_pkg::CFG_PWC_BIT] &&
          (r_reg.shutter == astc_pkg::SHUTTER_PULSE);

    // Trigger edge; the external one is dropped under the menu
    r_next.trig_d = trig_q;
    fall     = r_reg.trig_d & ~trig_q;
    ext_fire = fall && !menu &&
               (mode == astc_pkg::MODE_ASYNC);
    led_fire = ext_fire;
    r_next.led = led_on;

    // Line timing: one-cycle sync pulse each line
    r_next.hs = (r_reg.line_pix == LW'(LINE_CYCLES - 1));
    if (r_reg.line_pix == LW'(LINE_CYCLES - 1)) begin
      r_next.line_pix = '0;
    end else begin
      r_next.line_pix = r_reg.line_pix + LW'(1);
    end

    // Periodic internal trigger while the menu is shown
    menu_fire = 1'b0;
    if (!menu) begin
      r_next.menu_lines = '0;
    end else if (r_reg.hs) begin
      if (r_reg.menu_lines >= r_reg.menu_period - LW'(1)) begin
        r_next.menu_lines = '0;
        menu_fire = 1'b1;
      end else begin
        r_next.menu_lines = r_reg.menu_lines + LW'(1);
      end
    end

    accept = (ext_fire || r_reg.sw_trig || menu_fire) &&
             (r_reg.state == astc_pkg::ST_IDLE) &&
             (mode == astc_pkg::MODE_ASYNC);

    // Exposure sequence
    unique case (r_reg.state)
      astc_pkg::ST_IDLE: begin
        if (accept) begin
          r_next.internal = !ext_fire;
          r_next.lines    = '0;
          r_next.target   = (r_reg.exposure == '0) ? LW'(1)
                                                   : r_reg.exposure;
          if (hreset) begin
            // Accept cycle is the first pixel of the new line
            r_next.line_pix = LW'(1);
            r_next.hs       = 1'b0;
            if (pwm && ext_fire) begin
              r_next.state = astc_pkg::ST_MEASURE;
            end else begin
              r_next.state = astc_pkg::ST_EXPOSE;
            end
          end else begin
            r_next.state = astc_pkg::ST_ARMED;
          end
        end
      end
      astc_pkg::ST_ARMED: begin
        if (r_reg.hs) begin
          if (pwm && !r_reg.internal) begin
            r_next.state = astc_pkg::ST_MEASURE;
          end else begin
            r_next.state = astc_pkg::ST_EXPOSE;
          end
        end
      end
      astc_pkg::ST_MEASURE: begin
        // Pixel-accurate sampling with line reset, else at line sync
        sample = hreset ? 1'b1 : r_reg.hs;
        // A line that completes in the sampling cycle still counts
        done_lines = r_reg.lines;
        if (r_reg.hs && r_reg.lines != '1) begin
          done_lines = r_reg.lines + LW'(1);
        end
        if (sample && trig_q) begin
          r_next.measured = (done_lines == '0) ? LW'(1)
                                               : done_lines;
          r_next.target   = (done_lines == '0) ? LW'(1)
                                               : done_lines;
          r_next.lines    = '0;
          r_next.state    = astc_pkg::ST_EXPOSE;
        end else begin
          r_next.lines = done_lines;
        end
      end
      astc_pkg::ST_EXPOSE: begin
        if (r_reg.hs) begin
          if (r_reg.lines + LW'(1) >= r_reg.target) begin
            r_next.lines = '0;
            r_next.state = astc_pkg::ST_READOUT;
          end else begin
            r_next.lines = r_reg.lines + LW'(1);
          end
        end
      end
      astc_pkg::ST_READOUT: begin
        if (r_reg.hs) begin
          if (r_reg.lines >= LW'(READOUT_LINES - 1)) begin
            r_next.lines = '0;
            r_next.state = astc_pkg::ST_IDLE;
          end else begin
            r_next.lines = r_reg.lines + LW'(1);
          end
        end
      end
      default: begin
        r_next.state = astc_pkg::ST_IDLE;
      end
    endcase

    r_next.busy     = (r_next.state != astc_pkg::ST_IDLE);
    r_next.exposing = (r_next.state == astc_pkg::ST_EXPOSE);

    // Free-running frame for the continuous strobe
    if (r_reg.hs) begin
      if (r_reg.cont_line >= LW'(FRAME_LINES - 1)) begin
        r_next.cont_line = '0;
      end else begin
        r_next.cont_line = r_reg.cont_line + LW'(1);
      end
    end

    // Strobe timing in both shutter modes, pin source select
    if (mode == astc_pkg::MODE_ASYNC) begin
      strobe_t = r_next.exposing;
    end else if (mode == astc_pkg::MODE_CONT) begin
      // Exposure as long as the frame keeps the strobe on throughout
      strobe_t = (r_reg.exposure >= LW'(FRAME_LINES)) ||
                 (r_reg.cont_line >=
                  LW'(FRAME_LINES) - r_reg.exposure);
    end
    sel = {r_reg.configuration_word[astc_pkg::CFG_STROBE_TIMING_OUT_HI_BIT],
           r_reg.configuration_word[astc_pkg::CFG_STROBE_TIMING_OUT_LO_BIT]};
    unique case (sel)
      astc_pkg::STROBE_TIMING_OUT_SEL_STROBE: r_next.strobe = ~strobe_t;
      astc_pkg::STROBE_TIMING_OUT_SEL_BUSY:   r_next.strobe = ~r_next.busy;
      default:                   r_next.strobe = 1'b1;
    endcase

    // Permissions: gain, exposure, long exposure, iris
    unique case (mode)
      astc_pkg::MODE_ASYNC: r_next.allowed = 4'h0;
      astc_pkg::MODE_CONT:  r_next.allowed = 4'hF;
      default:              r_next.allowed = 4'hD;
    endcase
    r_next.aec_active = (mode == astc_pkg::MODE_CONT) &&
      r_reg.configuration_word[astc_pkg::CFG_AEC_BIT];

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        astc_pkg::ADDR_CONFIG:
          r_next.configuration_word =
            reg_wdata[astc_pkg::CONFIG_W-1:0];
        astc_pkg::ADDR_SHUTTER:
          r_next.shutter = reg_wdata[astc_pkg::SHUTTER_W-1:0];
        astc_pkg::ADDR_EXPOSURE:
          r_next.exposure = reg_wdata[LW-1:0];
        astc_pkg::ADDR_COMMAND:
          r_next.sw_trig = reg_wdata[astc_pkg::CMD_SW_TRIG_BIT];
        astc_pkg::ADDR_MENU_PERIOD:
          r_next.menu_period = reg_wdata[LW-1:0];
        default: begin
        end
      endcase
    end

    // Register reads, data in the following cycle only
    if (reg_rd) begin
      unique case (reg_addr)
        astc_pkg::ADDR_CONFIG:
          r_next.rdata = {22'h0, r_reg.configuration_word};
        astc_pkg::ADDR_SHUTTER:
          r_next.rdata = {28'h0, r_reg.shutter};
        astc_pkg::ADDR_EXPOSURE:
          r_next.rdata = {16'h0, r_reg.exposure};
        astc_pkg::ADDR_STATUS:
          r_next.rdata = {21'h0, trig_q, r_reg.aec_active,
                          r_reg.allowed, mode, r_reg.led,
                          r_reg.exposing, r_reg.busy};
        astc_pkg::ADDR_MEASURED:
          r_next.rdata = {16'h0, r_reg.measured};
        astc_pkg::ADDR_MENU_PERIOD:
          r_next.rdata = {16'h0, r_reg.menu_period};
        default:
          r_next.rdata = 32'h0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '{
        configuration_word: astc_pkg::CONFIG_RESET,
        shutter:            astc_pkg::SHUTTER_RESET,
        exposure:           astc_pkg::EXPOSURE_RESET,
        menu_period:        astc_pkg::MENU_PERIOD_RESET,
        state:              astc_pkg::ST_IDLE,
        trig_d:             1'b1,
        strobe:             1'b1,
        allowed:            4'hD,
        default:            '0
      };
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata             = r_reg.rdata;
  assign strobe_pin            = r_reg.strobe;
  assign indicator_led         = r_reg.led;
  assign busy                  = r_reg.busy;
  assign exposing              = r_reg.exposing;
  assign horizontal_sync_pulse = r_reg.hs;
  assign agc_allowed           = r_reg.allowed[0];
  assign aec_allowed           = r_reg.allowed[1];
  assign long_exposure_allowed = r_reg.allowed[2];
  assign auto_iris_allowed     = r_reg.allowed[3];
  assign aec_active            = r_reg.aec_active;

endmodule
`default_nettype wire

//--- test/astc_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module astc_checker #(
  parameter int LINE_CYCLES = 8,
  parameter int LED_CYCLES  = 50
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Watched ports
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        trigger_n_pin,
  input wire logic        indicator_led,
  input wire logic        busy,
  input wire logic        exposing,
  input wire logic        horizontal_sync_pulse,
  input wire logic        agc_allowed,
  input wire logic        aec_allowed,
  input wire logic        long_exposure_allowed,
  input wire logic        auto_iris_allowed,
  input wire logic        aec_active
);
  logic [15:0] hs_gap;
  logic [15:0] led_run;
  logic [15:0] fall_age;
  logic        trig_q;
  logic [3:0]  perms;

  assign perms = {agc_allowed, aec_allowed, long_exposure_allowed,
                  auto_iris_allowed};

  // Ages since line pulse and trigger fall, length of lit run
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_gap   <= 16'(LINE_CYCLES);
      led_run  <= 16'h0000;
      fall_age <= 16'hFFFF;
      trig_q   <= 1'b1;
    end else begin
      trig_q   <= trigger_n_pin;
      hs_gap   <= horizontal_sync_pulse ? 16'h0001 :
                  (hs_gap == 16'hFFFF ? hs_gap : hs_gap + 16'h0001);
      led_run  <= indicator_led ? led_run + 16'h0001 : 16'h0000;
      fall_age <= (trig_q && !trigger_n_pin) ? 16'h0000 :
                  (fall_age == 16'hFFFF ? fall_age : fall_age + 16'h0001);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read cycle");
  property p_async_perm;
    busy |-> perms == 4'h0;
  endproperty
  a_async_perm: assert property (p_async_perm)
    else $error("auto functions allowed in async shutter");
  property p_aec_mode;
    aec_active |-> perms == 4'hF;
  endproperty
  a_aec_mode: assert property (p_aec_mode)
    else $error("continuous mode with auto exposure lacks functions");
  property p_aec_not_async;
    aec_active |-> !busy && !exposing;
  endproperty
  a_aec_not_async: assert property (p_aec_not_async)
    else $error("auto exposure active during async exposure");
  property p_expose_busy;
    exposing |-> busy;
  endproperty
  a_expose_busy: assert property (p_expose_busy)
    else $error("exposing without busy");
  property p_hs_spacing;
    horizontal_sync_pulse |-> hs_gap >= 16'(LINE_CYCLES);
  endproperty
  a_hs_spacing: assert property (p_hs_spacing)
    else $error("line pulses too close");
  property p_hs_bound;
    hs_gap <= 16'(2 * LINE_CYCLES + 2);
  endproperty
  a_hs_bound: assert property (p_hs_bound)
    else $error("line pulse missing");
  property p_led_cause;
    $rose(indicator_led) |-> fall_age <= 16'h0008;
  endproperty
  a_led_cause: assert property (p_led_cause)
    else $error("indicator lit without trigger fall");
  property p_led_min;
    $fell(indicator_led) |-> led_run >= 16'(LED_CYCLES);
  endproperty
  a_led_min: assert property (p_led_min)
    else $error("indicator lit too briefly");
  property p_led_max;
    indicator_led |-> fall_age <= 16'(LED_CYCLES + 10);
  endproperty
  a_led_max: assert property (p_led_max)
    else $error("indicator lit too long after last fall");

  // Main scenarios reached
  c_expose: cover property ($rose(exposing));
  c_retrig: cover property (indicator_led && fall_age == 16'h0000);
  c_aec:    cover property ($rose(aec_active));
endmodule

bind astc_top astc_checker #(
  .LINE_CYCLES (LINE_CYCLES),
  .LED_CYCLES  (LED_CYCLES)
) u_chk (
  .clk                   (clk),
  .arst_n                (arst_n),
  .reg_rd                (reg_rd),
  .reg_rdata             (reg_rdata),
  .trigger_n_pin         (trigger_n_pin),
  .indicator_led         (indicator_led),
  .busy                  (busy),
  .exposing              (exposing),
  .horizontal_sync_pulse (horizontal_sync_pulse),
  .agc_allowed           (agc_allowed),
  .aec_allowed           (aec_allowed),
  .long_exposure_allowed (long_exposure_allowed),
  .auto_iris_allowed     (auto_iris_allowed),
  .aec_active            (aec_active)
);
`default_nettype wire

//--- test/astc_user_unit.sv
`timescale 1ns/10ps
`default_nettype none
module astc_user_unit (
  // Clock
  input  wire logic        clk,
  // Strobe light input and trigger output
  input  wire logic        strobe_pin,
  output var  logic        trigger_n,
  output var  logic [15:0] strobe_low_cycles
);
  initial trigger_n = 1'b1;
  initial strobe_low_cycles = 16'h0000;

  // Active-low trigger pulse of a given length in clocks
  task automatic pulse(input int low_cycles);
    @(posedge clk);
    trigger_n <= 1'b0;
    repeat (low_cycles) @(posedge clk);
    trigger_n <= 1'b1;
  endtask

  // Light is fired while the pin is low
  always @(posedge clk) begin
    if (strobe_pin === 1'b0)
      strobe_low_cycles <= strobe_low_cycles + 16'h0001;
  end
endmodule
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk;
  logic        arst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        trig_n;
  logic        strobe_pin, led, busy, exposing, hs;
  logic        auto_gain_control, aec, lng, iris, aec_act;
  logic [15:0] slow;
  int          k;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          len;
  int          s0;

  astc_top #(.LINE_CYCLES(8), .READOUT_LINES(3), .FRAME_LINES(10),
    .LED_CYCLES(50)) u_dut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trigger_n_pin(trig_n), .strobe_pin(strobe_pin), .indicator_led(led),
    .busy(busy), .exposing(exposing), .horizontal_sync_pulse(hs),
    .agc_allowed(auto_gain_control), .aec_allowed(aec), .long_exposure_allowed(lng),
    .auto_iris_allowed(iris), .aec_active(aec_act));
  astc_user_unit u_user (.clk(clk), .strobe_pin(strobe_pin),
    .trigger_n(trig_n), .strobe_low_cycles(slow));

  // 40 MHz clock and run limit
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp, what);
  endtask
  // Length of the next exposure in clocks
  task automatic measure(output int n);
    int k;
    n = 0;
    // Look only after the launching edge has settled
    for (k = 0; k < 300 && exposing !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    while (exposing === 1'b1 && n < 400) begin
      @(posedge clk); #1 n++;
    end
  endtask
  task automatic idle_wait();
    int k;
    for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk);
    check(busy, 1'b0, "busy end");
  endtask

  initial begin
    arst_n    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values and unmapped place
    rchk(astc_pkg::ADDR_CONFIG, 32'h0, "config");
    rchk(astc_pkg::ADDR_SHUTTER, 32'h0, "shutter");
    rchk(astc_pkg::ADDR_EXPOSURE, 32'h10, "expo");
    rchk(8'h1C, 32'h0, "unmapped");
    check({auto_gain_control, aec, lng, iris}, 4'hB, "no shutter perms");
    check(strobe_pin, 1'b1, "strobe default");
    // Select bits in bits five and six, status read-only
    wr(astc_pkg::ADDR_CONFIG, 32'h60);
    rchk(astc_pkg::ADDR_CONFIG, 32'h60, "select bits");
    wr(astc_pkg::ADDR_STATUS, 32'h3FF);
    rchk(astc_pkg::ADDR_STATUS, 32'h5A0, "status");
    check(strobe_pin, 1'b1, "strobe sel 11");
    // Auto exposure with shutter zero goes continuous
    wr(astc_pkg::ADDR_CONFIG, 32'h4);
    repeat (2) @(posedge clk);
    check(aec_act, 1'b1, "aec active");
    rchk(astc_pkg::ADDR_STATUS, 32'h7E8, "status cont");
    rchk(astc_pkg::ADDR_SHUTTER, 32'h0, "shutter kept");
    // Continuous strobe timing on the pin
    wr(astc_pkg::ADDR_CONFIG, 32'h20);
    wr(astc_pkg::ADDR_SHUTTER, 32'h1);
    s0 = slow;
    repeat (200) @(posedge clk);
    check(slow != s0, 1'b1, "cont strobe");
    // Preset with line reset, busy on the pin
    wr(astc_pkg::ADDR_EXPOSURE, 32'h2);
    wr(astc_pkg::ADDR_CONFIG, 32'h142);
    repeat (2) @(posedge clk);
    check({auto_gain_control, aec, lng, iris}, 4'h0, "async perms");
    fork u_user.pulse(10); measure(len); join
    check(len, 16, "preset length");
    repeat (2) @(posedge clk);
    check(strobe_pin, 1'b0, "busy on pin");
    check(led, 1'b1, "led lit");
    u_user.pulse(20);
    repeat (4) @(posedge clk);
    check(exposing, 1'b0, "refused while busy");
    idle_wait();
    repeat (2) @(posedge clk);
    check(strobe_pin, 1'b1, "busy end pin");
    fork u_user.pulse(30); measure(len); join
    check(len, 16, "width ignored");
    idle_wait();
    // Pulse width with line reset, strobe timing on the pin
    wr(astc_pkg::ADDR_CONFIG, 32'h123);
    wr(astc_pkg::ADDR_SHUTTER, 32'h9);
    for (int i = 0; i < 2; i++) begin
      s0 = slow;
      fork u_user.pulse(i ? 20 : 27); measure(len); join
      check((len + 4) / 8, i ? 2 : 3, "pw length");
      rchk(astc_pkg::ADDR_MEASURED, i ? 2 : 3, "measured");
      check((slow - s0 + 4) / 8, i ? 2 : 3, "strobe span");
      idle_wait();
    end
    // Software trigger
    wr(astc_pkg::ADDR_CONFIG, 32'h100);
    wr(astc_pkg::ADDR_SHUTTER, 32'h1);
    wr(astc_pkg::ADDR_COMMAND, 32'h1);
    repeat (2) @(posedge clk);
    check(busy, 1'b1, "soft trigger");
    idle_wait();
    // Retriggered indicator
    u_user.pulse(10);
    repeat (30) @(posedge clk);
    u_user.pulse(10);
    repeat (40) @(posedge clk);
    check(led, 1'b1, "led extended");
    idle_wait();
    repeat (70) @(posedge clk);
    check(led, 1'b0, "led off");
    // Menu: internal triggers, external ignored
    wr(astc_pkg::ADDR_MENU_PERIOD, 32'h2);
    wr(astc_pkg::ADDR_CONFIG, 32'h300);
    u_user.pulse(10);
    repeat (4) @(posedge clk);
    check(led, 1'b0, "menu ignores pin");
    idle_wait();
    // Catch the next internal trigger while still armed
    for (k = 0; k < 100 && busy !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    rchk(astc_pkg::ADDR_STATUS, 32'h411, "menu busy");
    report_and_stop();
  end
endmodule
`default_nettype wire
